// File: hpc_pkg.sv
// Shared types and constants for the host-side PCI control-signal controller.
// Assumes one 100 MHz clock and a synchronous active-low reset for all users.
// How it works
// - The master asserts frame to start, holds it, and releases it in the final phase.
// - A data phase completes only when initiator ready and target ready are both low.
// - A master ends its transaction when the target drives stop.
// - Init device select acts as configuration chip select; driven by the host.
// - A master watches device select to learn whether anyone claimed the cycle.
// - The arbiter asserts the device's own grant line to hand it the bus.
// - The data receiver asserts parity error two clocks after detecting it.
// - Parity error stays low at least one clock per failing data phase.
// - No parity error report before claiming with device select and completing a phase.
// - The system supplies at least 16 MHz; stopping it only via clock-run.
// - Clock-run pauses the clock; the device may refuse stopping or request restart.
// - A sustained line is driven high one clock before floating; owners wait a clock. Clock-run is floated straight from low, not driven high first.
// - Parity is even over the 32 address/data lines and four command lines.
package hpc_pkg;

    // Raw or synchronised pin levels coming from the bus.
    typedef struct packed {
        logic        frame_n;
        logic        irdy_n;
        logic        trdy_n;
        logic        stop_n;
        logic        devsel_n;
        logic        req_n;
        logic        inta_n;
        logic        serr_n;
        logic        perr_n;
        logic        pme_n;
        logic        clkrun_n;
        logic        wake;
        logic [31:0] ad;
        logic [3:0]  cbe_n;
        logic        par;
    } hpc_pin_in_t;

    // Pin drives; every *_oe_n is low while this end drives the line.
    typedef struct packed {
        logic frame_n;
        logic frame_oe_n;
        logic irdy_n;
        logic irdy_oe_n;
        logic trdy_n;
        logic trdy_oe_n;
        logic stop_n;
        logic stop_oe_n;
        logic devsel_n;
        logic devsel_oe_n;
        logic perr_n;
        logic perr_oe_n;
        logic gnt_n;
        logic idsel;
        logic clkrun_n;
        logic clkrun_oe_n;
        logic rst_n;
        logic isolate_n;
        logic power_up_reset_n;
    } hpc_pin_out_t;

    typedef struct packed {
        logic start;
        logic cfg;
        logic wr;
    } hpc_cmd_t;

    typedef struct packed {
        logic bus_reset;
        logic isolate;
        logic power_up_reset;
        logic clk_stop;
        logic tgt_stop;
    } hpc_ctl_t;

    typedef struct packed {
        logic cmd_ready;
        logic done;
        logic stopped;
        logic abort;
        logic tgt_done;
        logic perr_evt;
        logic serr_evt;
        logic irq;
        logic pme;
        logic wake_evt;
        logic clk_stop_ok;
    } hpc_stat_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_DATA  = 3'h3,
        ST_PARK  = 3'h2,
        ST_FLOAT = 3'h6,
        ST_TGT   = 3'h7,
        ST_TPARK = 3'h5
    } hpc_st_t;

    typedef struct packed {
        hpc_st_t      st;
        logic         cfg;
        logic         wr;
        logic         mst;
        logic [3:0]   wait_cnt;
        logic         claimed;
        logic         tcmd_wr;
        logic         chk_pend;
        logic [35:0]  chk_word;
        logic         err_r;
        logic         serr_prev;
        logic         wake_prev;
        hpc_pin_out_t pins;
        hpc_stat_t    stat;
        logic [31:0]  rd_data;
    } hpc_state_t;

    // Cycles without a device select before a master abort, two sync stages included.
    localparam logic [3:0]   DEVSEL_WAIT = 4'h8;
    localparam hpc_pin_in_t  PIN_IN_IDLE = {11'h7ff, 1'h0, 32'h0, 4'hf, 1'h0};
    localparam hpc_pin_out_t PIN_OUT_RST = {12'hfff, 1'h1, 1'h0, 2'h3, 3'h2};
    localparam hpc_state_t   STATE_RST   = '{st: ST_IDLE, pins: PIN_OUT_RST, default: '0};

endpackage : hpc_pkg

// File: hpc_sync.sv
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; words are not kept coherent across bits.
`timescale 1ns/1ps
`default_nettype none
module hpc_sync #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         clock_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            meta_r <= INIT;
            q_out  <= INIT;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule : hpc_sync
`default_nettype wire

// File: hpc_host.sv
// Host-side controller for the PCI control lines of an attached network device.
// Assumes the AD and command drive is handled elsewhere; this block frames,
// arbitrates, claims device-mastered cycles and checks parity on received data.
`timescale 1ns/1ps
`default_nettype none
module hpc_host
    import hpc_pkg::*;
(
    input  wire logic         clock_in,
    input  wire logic         nrst_in,
    input  wire hpc_pin_in_t  pin_in,
    output var  hpc_pin_out_t pin_out,
    input  wire hpc_cmd_t     cmd_in,
    input  wire hpc_ctl_t     ctl_in,
    output var  hpc_stat_t    stat_out,
    output var  logic [31:0]  rd_data_out
);
    hpc_pin_in_t pin_s;
    hpc_state_t  s;
    hpc_state_t  n;
    logic        det;

    // Bus levels come from another agent's timing, so every pin is synchronised.
    // The two-cycle lag means decode is always slow; devices must tolerate that.
    hpc_sync #(
        .W    ($bits(hpc_pin_in_t)),
        .INIT (PIN_IN_IDLE)
    ) u_sync (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .d_in     (pin_in),
        .q_out    (pin_s)
    );

    function automatic logic par_bad(input logic [35:0] word, input logic par);
        par_bad = ^{word, par};
    endfunction : par_bad

    always_comb begin
        n                = s;
        n.stat.done      = 1'b0;
        n.stat.stopped   = 1'b0;
        n.stat.abort     = 1'b0;
        n.stat.tgt_done  = 1'b0;
        n.chk_pend       = 1'b0;

        // Received data is checked one clock after completion, when parity is valid.
        det = s.chk_pend && par_bad(s.chk_word, pin_s.par);
        n.err_r         = det;
        n.stat.perr_evt = det;
        n.pins.perr_n    = !s.err_r;
        n.pins.perr_oe_n = !(s.err_r || (!s.pins.perr_oe_n && !s.pins.perr_n));

        n.serr_prev     = pin_s.serr_n;
        n.stat.serr_evt = s.serr_prev && !pin_s.serr_n;
        n.stat.irq      = !pin_s.inta_n;
        n.stat.pme      = !pin_s.pme_n;
        n.wake_prev     = pin_s.wake;
        n.stat.wake_evt = pin_s.wake && !s.wake_prev;

        n.pins.rst_n            = !ctl_in.bus_reset;
        n.pins.isolate_n        = !ctl_in.isolate;
        n.pins.power_up_reset_n = !ctl_in.power_up_reset;
        // Holding clock-run low keeps the clock running; a release asks to stop it.
        n.pins.clkrun_n    = 1'b0;
        n.pins.clkrun_oe_n = ctl_in.clk_stop;
        n.stat.clk_stop_ok = s.pins.clkrun_oe_n && pin_s.clkrun_n;

        case (s.st)
            ST_IDLE: begin
                if (!pin_s.frame_n) begin
                    n.st               = ST_TGT;
                    n.tcmd_wr          = pin_s.cbe_n[0];
                    n.pins.devsel_n    = 1'b0;
                    n.pins.devsel_oe_n = 1'b0;
                    n.pins.trdy_n      = 1'b0;
                    n.pins.trdy_oe_n   = 1'b0;
                    n.pins.stop_n      = !ctl_in.tgt_stop;
                    n.pins.stop_oe_n   = 1'b0;
                end else if (s.stat.cmd_ready && cmd_in.start) begin
                    n.st              = ST_ADDR;
                    n.cfg             = cmd_in.cfg;
                    n.wr              = cmd_in.wr;
                    n.mst             = 1'b1;
                    n.wait_cnt        = 4'h0;
                    n.claimed         = 1'b0;
                    n.pins.frame_n    = 1'b0;
                    n.pins.frame_oe_n = 1'b0;
                    n.pins.irdy_n     = 1'b1;
                    n.pins.irdy_oe_n  = 1'b0;
                    n.pins.idsel      = cmd_in.cfg;
                end
            end
            ST_ADDR: begin
                // Single data phase, so frame is released as the phase opens.
                n.st            = ST_DATA;
                n.pins.frame_n  = 1'b1;
                n.pins.irdy_n   = 1'b0;
                n.pins.idsel    = 1'b0;
            end
            ST_DATA: begin
                n.wait_cnt = s.wait_cnt + 4'h1;
                if (!pin_s.devsel_n) begin
                    n.claimed = 1'b1;
                end
                if (!pin_s.trdy_n && !pin_s.devsel_n) begin
                    n.st        = ST_PARK;
                    n.stat.done = 1'b1;
                    if (!s.wr) begin
                        n.rd_data  = pin_s.ad;
                        n.chk_pend = 1'b1;
                        n.chk_word = {pin_s.ad, pin_s.cbe_n};
                    end
                end
                if (!pin_s.stop_n) begin
                    n.st           = ST_PARK;
                    n.stat.stopped = 1'b1;
                end else if (pin_s.trdy_n && !s.claimed && pin_s.devsel_n
                             && s.wait_cnt == DEVSEL_WAIT) begin
                    n.st         = ST_PARK;
                    n.stat.abort = 1'b1;
                end
            end
            ST_PARK: begin
                n.st           = ST_FLOAT;
                n.pins.irdy_n  = 1'b1;
                n.pins.frame_n = 1'b1;
            end
            ST_TGT: begin
                if (!pin_s.irdy_n) begin
                    n.stat.tgt_done = 1'b1;
                    if (s.tcmd_wr) begin
                        n.chk_pend = 1'b1;
                        n.chk_word = {pin_s.ad, pin_s.cbe_n};
                    end
                end
                if (pin_s.frame_n) begin
                    n.st = ST_TPARK;
                end
            end
            ST_TPARK: begin
                n.st            = ST_FLOAT;
                n.pins.devsel_n = 1'b1;
                n.pins.trdy_n   = 1'b1;
                n.pins.stop_n   = 1'b1;
            end
            ST_FLOAT: begin
                n.st               = ST_IDLE;
                n.mst              = 1'b0;
                n.pins.frame_oe_n  = 1'b1;
                n.pins.irdy_oe_n   = 1'b1;
                n.pins.trdy_oe_n   = 1'b1;
                n.pins.stop_oe_n   = 1'b1;
                n.pins.devsel_oe_n = 1'b1;
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // The device gets the bus only while this end is not mastering.
        n.pins.gnt_n = !(!pin_s.req_n && !n.mst && !s.mst);
        n.stat.cmd_ready = (n.st == ST_IDLE) && pin_s.req_n && n.pins.gnt_n
                           && pin_s.frame_n && !ctl_in.bus_reset && !ctl_in.isolate;
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            s <= STATE_RST;
        end else begin
            s <= n;
        end
    end

    assign pin_out     = s.pins;
    assign stat_out    = s.stat;
    assign rd_data_out = s.rd_data;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    sequence s_addr_phase;
        s.st == ST_ADDR && !s.pins.frame_n && !s.pins.frame_oe_n;
    endsequence

    sequence s_final_phase;
        s.st == ST_DATA && s.pins.frame_n && !s.pins.irdy_n;
    endsequence

    a_frame_final_phase: assert property (s_addr_phase |=> s_final_phase)
        else $error("frame not released in the final data phase");
    a_start_frames: assert property (s.st == ST_IDLE && pin_s.frame_n && s.stat.cmd_ready
                                     && cmd_in.start |=> s_addr_phase)
        else $error("accepted start did not assert frame");
    a_done_both_low: assert property (s.stat.done |-> $past(!pin_s.trdy_n)
                                      && $past(!s.pins.irdy_n))
        else $error("completion without both ready lines low");
    a_stop_ends: assert property (s.st == ST_DATA && !pin_s.stop_n
                                  |=> s.st == ST_PARK ##1 s.st == ST_FLOAT)
        else $error("stop did not end the transaction");
    a_idsel_cfg: assert property (s.pins.idsel |-> s.st == ST_ADDR && s.cfg)
        else $error("idsel outside a configuration address phase");
    a_claim_devsel: assert property (s.st == ST_IDLE && !pin_s.frame_n
                                     |=> !s.pins.devsel_n && !s.pins.devsel_oe_n)
        else $error("device-mastered cycle not claimed");
    a_grant_req: assert property (!pin_s.req_n && !s.mst && s.st != ST_ADDR
                                  |=> !s.pins.gnt_n)
        else $error("request not granted");
    a_perr_two: assert property (det |-> ##2 (!s.pins.perr_n && !s.pins.perr_oe_n))
        else $error("parity error not driven two clocks after detection");
    // The last low cycle of a report is the one with no further error queued behind it.
    a_perr_park: assert property (!s.pins.perr_n && !s.pins.perr_oe_n && !s.err_r
                                  |=> (s.pins.perr_n && !s.pins.perr_oe_n))
        else $error("parity error line floated without driving high");
    a_serr_event: assert property ($fell(pin_s.serr_n) |=> s.stat.serr_evt)
        else $error("system error not reported");
    a_irq_level: assert property (!pin_s.inta_n |=> s.stat.irq)
        else $error("interrupt level not followed");
endmodule : hpc_host
`default_nettype wire

// File: hpc_dev_model.sv
// Behavioural model of the attached network device on the far side of the host controller.
// Assumes the host's pin drives as input and returns resolved bus levels to the host.
`timescale 1ns/1ps
`default_nettype none
module hpc_dev_model
    import hpc_pkg::*;
#(
    parameter logic [31:0] DATA = 32'h0
) (
    input  wire logic         clock_in,
    input  wire hpc_pin_out_t host_in,
    input  wire logic [1:0]   mode_in,
    input  wire logic         bad_in,
    input  wire logic         mreq_in,
    input  wire logic [3:0]   misc_in,
    output var  hpc_pin_in_t  pin_out
);
    logic        fr, ir, tr, sp, dv, rq, tg;
    logic [1:0]  mph;
    logic [3:0]  cnt;
    logic [31:0] ad;
    logic [3:0]  cbe;
    // Shared lines have pull-ups, so a line nobody drives reads high.
    wire b_fr = fr & (host_in.frame_oe_n | host_in.frame_n);
    wire b_ir = ir & (host_in.irdy_oe_n | host_in.irdy_n);
    wire b_tr = tr & (host_in.trdy_oe_n | host_in.trdy_n);
    wire b_sp = sp & (host_in.stop_oe_n | host_in.stop_n);
    wire b_dv = dv & (host_in.devsel_oe_n | host_in.devsel_n);
    always_comb begin
        pin_out = '{frame_n: b_fr, irdy_n: b_ir, trdy_n: b_tr, stop_n: b_sp, devsel_n: b_dv,
                    req_n: rq, inta_n: !misc_in[3], serr_n: !misc_in[1],
                    perr_n: host_in.perr_oe_n | host_in.perr_n, pme_n: !misc_in[2],
                    clkrun_n: host_in.clkrun_oe_n, wake: misc_in[0],
                    ad: ad, cbe_n: cbe, par: ^{ad, cbe} ^ bad_in};
    end
    always_ff @(posedge clock_in) begin
        if (!host_in.rst_n || !host_in.isolate_n || !host_in.power_up_reset_n) begin
            {fr, ir, tr, sp, dv, rq} <= 6'h3f;
            {tg, mph, cnt, ad, cbe} <= {39'h0, 4'hf};
        end else begin
            if (!tg && mph == 2'h0) ad <= ~ad;
            if (!tg && !host_in.frame_oe_n && !host_in.frame_n) begin
                tg <= 1'b1;
                cnt <= 4'h0;
            end
            if (tg) begin
                cnt <= cnt + 4'h1;
                if (cnt == (mode_in == 2'h1 ? 4'h4 : 4'h0) && mode_in != 2'h3) begin
                    {dv, tr, sp} <= {1'b0, mode_in == 2'h2, mode_in != 2'h2};
                    {ad, cbe} <= {DATA, 4'h0};
                end
                if (cnt > 4'h1 && b_fr && b_ir) begin
                    {dv, tr, sp, tg} <= 4'he;
                end
            end
            case (mph)
                2'h0: if (mreq_in) begin
                    {rq, mph} <= 3'h1;
                end
                2'h1: if (!host_in.gnt_n && b_fr && b_ir) begin
                    {fr, rq, cbe, ad, mph} <= {2'h1, 4'h7, DATA, 2'h2};
                end
                2'h2: begin
                    {fr, ir, cbe, mph} <= {2'h2, 4'h0, 2'h3};
                end
                default: if ((!b_tr && !b_dv) || !b_sp) begin
                    {ir, mph} <= 3'h4;
                end
            endcase
        end
    end
endmodule : hpc_dev_model
`default_nettype wire

// File: test_pci_cardbus_control_signals.sv
// Self-checking bench for the host-side control-signal controller.
// Assumes the device model answers on the bus and the bench drives user inputs.
`timescale 1ns/1ps
`default_nettype none
module test_pci_cardbus_control_signals;
    import hpc_pkg::*;
    typedef struct packed {
        logic       cfg;
        logic       wr;
        logic [1:0] mode;
        logic       bad;
        logic [3:0] exp;
    } hpc_row_t;
    localparam logic [31:0] DATA = 32'h5a3c_69e1;
    // Expected flags are done, stopped, abort and parity error.
    localparam hpc_row_t ROWS [5] = '{'{1'b1, 1'b0, 2'h0, 1'b0, 4'h8}, '{1'b0, 1'b1, 2'h1, 1'b0, 4'h8},
        '{1'b0, 1'b0, 2'h2, 1'b0, 4'h4}, '{1'b0, 1'b0, 2'h3, 1'b0, 4'h2},
        '{1'b0, 1'b0, 2'h0, 1'b1, 4'h9}};
    logic         clock_in, nrst_in, bad, mreq;
    logic [1:0]   mode;
    logic [3:0]   misc;
    hpc_pin_in_t  pin_in;
    hpc_pin_out_t pin_out;
    hpc_cmd_t     cmd_in;
    hpc_ctl_t     ctl_in;
    hpc_stat_t    stat_out;
    logic [31:0]  rd_data_out;
    int           err_count, checked, cyc, n, w;
    hpc_host dut (.clock_in(clock_in), .nrst_in(nrst_in), .pin_in(pin_in), .pin_out(pin_out),
        .cmd_in(cmd_in), .ctl_in(ctl_in), .stat_out(stat_out), .rd_data_out(rd_data_out));
    hpc_dev_model #(.DATA(DATA)) dev (.clock_in(clock_in), .host_in(pin_out), .mode_in(mode),
        .bad_in(bad), .mreq_in(mreq), .misc_in(misc), .pin_out(pin_in));
    always #5 clock_in = ~clock_in;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task print_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic run_host(input hpc_row_t r);
        logic [3:0] s;
        int         fr, pl, idl, k;
        {s, fr, pl, idl, k} = '0;
        {mode, bad} = {r.mode, r.bad};
        while (stat_out.cmd_ready !== 1'b1 && k < 50) begin
            @(negedge clock_in);
            k++;
        end
        cmd_in = '{start: 1'b1, cfg: r.cfg, wr: r.wr};
        @(negedge clock_in);
        cmd_in.start = 1'b0;
        repeat (30) begin
            s |= {stat_out.done, stat_out.stopped, stat_out.abort, stat_out.perr_evt};
            if (!pin_out.frame_oe_n && !pin_out.frame_n) fr++;
            if (!pin_out.perr_oe_n && !pin_out.perr_n) pl++;
            if (pin_out.idsel === 1'b1) idl = 1;
            @(negedge clock_in);
        end
        chk(s, r.exp);
        chk(fr, 1);
        chk(idl, r.cfg);
        chk(pl, r.exp[0]);
        if (r.exp[3] && !r.wr) chk(rd_data_out, DATA);
    endtask : run_host
    task automatic run_dev(input logic stp, input logic bd);
        logic [4:0] s;
        s = '0;
        {ctl_in.tgt_stop, bad, mreq} = {stp, bd, 1'b1};
        @(negedge clock_in);
        mreq = 1'b0;
        repeat (30) begin
            s |= {!pin_out.gnt_n, !pin_out.devsel_oe_n && !pin_out.devsel_n, stat_out.tgt_done,
                  !pin_out.stop_oe_n && !pin_out.stop_n, stat_out.perr_evt};
            @(negedge clock_in);
        end
        chk(s, {3'h7, stp, bd});
    endtask : run_dev
    initial begin
        {clock_in, nrst_in, bad, mreq, mode, misc, cmd_in, ctl_in} = '0;
        {err_count, checked, cyc} = '0;
        repeat (12) @(negedge clock_in);
        chk(pin_out, PIN_OUT_RST);
        chk(stat_out, '0);
        nrst_in = 1'b1;
        repeat (6) @(negedge clock_in);
        foreach (ROWS[i]) run_host(ROWS[i]);
        run_dev(1'b0, 1'b0);
        run_dev(1'b1, 1'b0);
        run_dev(1'b0, 1'b1);
        misc = 4'hc;
        repeat (5) @(negedge clock_in);
        chk({stat_out.irq, stat_out.pme}, 2'h3);
        misc = 4'h3;
        @(negedge clock_in);
        {misc, n, w} = {4'h1, 64'h0};
        repeat (8) begin
            if (stat_out.serr_evt === 1'b1) n++;
            if (stat_out.wake_evt === 1'b1) w++;
            @(negedge clock_in);
        end
        chk({n[30:0], w[30:0], stat_out.irq, stat_out.pme}, {31'h1, 31'h1, 2'h0});
        {misc, ctl_in} = {4'h0, 5'h02};
        repeat (6) @(negedge clock_in);
        chk({pin_out.clkrun_oe_n, stat_out.clk_stop_ok}, 2'h3);
        ctl_in = 5'h1c;
        repeat (4) @(negedge clock_in);
        chk({pin_out.rst_n, pin_out.isolate_n, pin_out.power_up_reset_n, pin_out.clkrun_oe_n,
             stat_out.cmd_ready}, 5'h00);
        ctl_in = '0;
        repeat (6) @(negedge clock_in);
        chk({pin_out.rst_n, pin_out.clkrun_oe_n}, 2'h2);
        nrst_in = 1'b0;
        repeat (2) @(negedge clock_in);
        chk(pin_out, PIN_OUT_RST);
        nrst_in = 1'b1;
        repeat (4) @(negedge clock_in);
        print_verdict();
    end
endmodule : test_pci_cardbus_control_signals
`default_nettype wire
